// [hdl/swg_pkg.sv]
// constants and types for the sleep/wake event gating block
package swg_pkg;
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned HOLD_SEC    = 4;
  localparam longint unsigned HOLD_CYC_L = longint'(HOLD_SEC) * longint'(CLK_HZ);
  localparam int unsigned HOLD_CYC    = int'(HOLD_CYC_L);
  localparam int unsigned BLINK_HZ    = 1;
  localparam int unsigned BLINK_CYC   = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned SYNC_W      = 3;
  localparam logic [2:0]  SYNC_RST    = 3'h0;

  // power state codes presented on o_state
  typedef enum logic [4:0] {
    SWG_S0 = 5'h01,
    SWG_S1 = 5'h02,
    SWG_S3 = 5'h04,
    SWG_S4 = 5'h08,
    SWG_S5 = 5'h10
  } swg_state_t;
  localparam swg_state_t STATE_RST = SWG_S5;
endpackage : swg_pkg

// [hdl/swg_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module swg_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // pins and filtered levels
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_lvl
);
  import swg_pkg::*;

  initial begin
    if (WIDTH < 1) $error("swg_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  logic [WIDTH-1:0] nxt_lvl;

  // s1 is read only by s2 (metastability)
  always_comb begin
    nxt_lvl = lvl_ff;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_ff[i] == s3_ff[i]) nxt_lvl[i] = s2_ff[i];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff  <= i_pin;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign o_lvl = lvl_ff;
endmodule : swg_sync
`default_nettype wire

// [hdl/swg_wake.sv]
// sleep state tracking, wake source gating and power button timing
//
// Functional notes
// - lan wake match request, from echo or directed frame, asks power-up.
// - usb activity wakes only from s1 or s3.
// - pci pme# wakes s1..s5 only while wake-on-pme enable is set.
// - keyboard activity wakes s1/s3; s4/s5 only via alt+prtscr or power key.
// - pcie wake# wakes from any of s1, s3, s4, s5.
// - serial activity wakes only from s1 or s3.
// - in s3, drives and fan unpowered, front power led blinks.
// - wake during s3 resumes from saved context, not cold boot.
// - button under 4 s toggles on/off or wakes; over 4 s forces soft-off.
`timescale 1ns/1ps
`default_nettype none
module swg_wake #(
  parameter int unsigned HOLD_CYCLES  = swg_pkg::HOLD_CYC,
  parameter int unsigned BLINK_CYCLES = swg_pkg::BLINK_CYC
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // sleep entry command from the system, one-cycle pulses
  input  wire logic       i_sleep_req,
  input  wire swg_pkg::swg_state_t i_sleep_tgt,
  // firmware settings
  input  wire logic       i_pme_en,
  input  wire logic       i_kbd_s5_en,
  // wake sources (pins, active high after board inversion)
  input  wire logic       i_lan_match,
  input  wire logic       i_usb_act,
  input  wire logic       i_pme,
  input  wire logic       i_kbd_act,
  input  wire logic       i_kbd_hotkey,
  input  wire logic       i_pcie_wake,
  input  wire logic       i_ser_act,
  input  wire logic       i_pwr_btn,
  // power sequencer handshake
  input  wire logic       i_pwr_ack,
  output logic            o_pwr_up_req,
  output logic            o_resume,
  output logic            o_lan_wake,
  // power and indication
  output logic            o_main_pwr_en,
  output logic            o_drive_pwr_en,
  output logic            o_fan_en,
  output logic            o_led,
  output swg_pkg::swg_state_t o_state
);
  import swg_pkg::*;

  initial begin
    if (HOLD_CYCLES < 2) $error("swg_wake: HOLD_CYCLES too small");
    if (BLINK_CYCLES < 1) $error("swg_wake: BLINK_CYCLES too small");
  end

  localparam int unsigned NSRC = 8;
  localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
  localparam int unsigned BW = $clog2(BLINK_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_MAX = HW'(HOLD_CYCLES);
  localparam logic [BW-1:0] BLINK_MAX = BW'(BLINK_CYCLES - 1);

  logic [NSRC-1:0] pin_lvl;
  logic lan_l, usb_l, pme_l, kbd_l, hot_l, pcie_l, ser_l, btn_l;

  swg_sync #(.WIDTH(NSRC)) swg_sync_i (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   ({i_lan_match, i_usb_act, i_pme, i_kbd_act,
               i_kbd_hotkey, i_pcie_wake, i_ser_act, i_pwr_btn}),
    .o_lvl   (pin_lvl)
  );
  assign {lan_l, usb_l, pme_l, kbd_l, hot_l, pcie_l, ser_l, btn_l} = pin_lvl;

  // state registers
  swg_state_t      state_ff, nxt_state;
  logic            req_ff, nxt_req;
  logic            resume_ff, nxt_resume;
  logic            lanw_ff, nxt_lanw;
  logic            btn_d_ff, nxt_btn_d;
  logic            forced_ff, nxt_forced;
  logic [HW-1:0]   hold_ff, nxt_hold;
  logic [BW-1:0]   blink_cnt_ff, nxt_blink_cnt;
  logic            blink_ff, nxt_blink;
  logic            main_ff, drv_ff, fan_ff, led_ff;
  logic            nxt_main, nxt_drv, nxt_fan, nxt_led;

  logic shallow, deep, asleep, wake_hit, btn_short, btn_long;

  always_comb begin
    shallow = (state_ff == SWG_S1) || (state_ff == SWG_S3);
    deep    = (state_ff == SWG_S4) || (state_ff == SWG_S5);
    asleep  = shallow || deep;
    wake_hit = 1'b0;
    if (asleep) begin
      if (lan_l) wake_hit = 1'b1;
      if (usb_l && shallow) wake_hit = 1'b1;
      if (pme_l && i_pme_en) wake_hit = 1'b1;
      if (kbd_l && shallow) wake_hit = 1'b1;
      if (hot_l && deep && i_kbd_s5_en) wake_hit = 1'b1;
      if (hot_l && shallow) wake_hit = 1'b1;
      if (pcie_l) wake_hit = 1'b1;
      if (ser_l && shallow) wake_hit = 1'b1;
    end
  end

  // button timing: release before hold limit is a short press
  always_comb begin
    nxt_btn_d  = btn_l;
    nxt_hold   = hold_ff;
    nxt_forced = forced_ff;
    btn_short  = 1'b0;
    btn_long   = 1'b0;
    if (btn_l) begin
      if (hold_ff != HOLD_MAX) nxt_hold = hold_ff + HW'(1);
      if (hold_ff == HOLD_MAX - HW'(1)) btn_long = 1'b1;
      if (hold_ff == HOLD_MAX - HW'(1)) nxt_forced = 1'b1;
    end else begin
      nxt_hold   = '0;
      nxt_forced = 1'b0;
      // short press acts on release so a long press never toggles first
      if (btn_d_ff && !forced_ff) btn_short = 1'b1;
    end
  end

  // state and handshake
  always_comb begin
    nxt_state  = state_ff;
    nxt_req    = req_ff;
    nxt_resume = resume_ff;
    nxt_lanw   = lan_l && asleep;
    if (btn_long) begin
      nxt_state  = SWG_S5;
      nxt_req    = 1'b0;
      nxt_resume = 1'b0;
    end else if (req_ff) begin
      // held until the sequencer acknowledges power-up
      if (i_pwr_ack) begin
        nxt_req   = 1'b0;
        nxt_state = SWG_S0;
      end
    end else if (asleep && (wake_hit || btn_short)) begin
      nxt_req    = 1'b1;
      nxt_resume = (state_ff != SWG_S5);
    end else if (state_ff == SWG_S0) begin
      if (btn_short) begin
        nxt_state = SWG_S5;
      end else if (i_sleep_req && (i_sleep_tgt == SWG_S1 || i_sleep_tgt == SWG_S3 ||
                                   i_sleep_tgt == SWG_S4 || i_sleep_tgt == SWG_S5)) begin
        // other codes would park the state outside the one-hot set
        nxt_state  = i_sleep_tgt;
        nxt_resume = 1'b0;
      end
    end
  end

  // blink divider, running only in s3
  always_comb begin
    nxt_blink_cnt = blink_cnt_ff;
    nxt_blink     = blink_ff;
    if (state_ff != SWG_S3) begin
      nxt_blink_cnt = '0;
      nxt_blink     = 1'b1;
    end else if (blink_cnt_ff == BLINK_MAX) begin
      nxt_blink_cnt = '0;
      nxt_blink     = !blink_ff;
    end else begin
      nxt_blink_cnt = blink_cnt_ff + BW'(1);
    end
  end

  // rails follow the next state so outputs stay one flop deep
  always_comb begin
    nxt_main = (nxt_state == SWG_S0) || (nxt_state == SWG_S1);
    nxt_drv  = nxt_main;
    nxt_fan  = (nxt_state == SWG_S0);
    case (nxt_state)
      SWG_S0, SWG_S1: nxt_led = 1'b1;
      SWG_S3:         nxt_led = nxt_blink;
      default:        nxt_led = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff     <= STATE_RST;
      req_ff       <= 1'b0;
      resume_ff    <= 1'b0;
      lanw_ff      <= 1'b0;
      btn_d_ff     <= 1'b0;
      forced_ff    <= 1'b0;
      hold_ff      <= '0;
      blink_cnt_ff <= '0;
      blink_ff     <= 1'b1;
      main_ff      <= 1'b0;
      drv_ff       <= 1'b0;
      fan_ff       <= 1'b0;
      led_ff       <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      req_ff       <= nxt_req;
      resume_ff    <= nxt_resume;
      lanw_ff      <= nxt_lanw;
      btn_d_ff     <= nxt_btn_d;
      forced_ff    <= nxt_forced;
      hold_ff      <= nxt_hold;
      blink_cnt_ff <= nxt_blink_cnt;
      blink_ff     <= nxt_blink;
      main_ff      <= nxt_main;
      drv_ff       <= nxt_drv;
      fan_ff       <= nxt_fan;
      led_ff       <= nxt_led;
    end
  end

  assign o_state        = state_ff;
  assign o_pwr_up_req   = req_ff;
  assign o_resume       = resume_ff;
  assign o_lan_wake     = lanw_ff;
  assign o_main_pwr_en  = main_ff;
  assign o_drive_pwr_en = drv_ff;
  assign o_fan_en       = fan_ff;
  assign o_led          = led_ff;
endmodule : swg_wake
`default_nettype wire

// [tb/swg_seq_model.sv]
// power sequencer model acking power-up after a delay
`timescale 1ns/1ps
`default_nettype none
module swg_seq_model #(parameter int unsigned DLY = 12) (
  // clock, reset and handshake
  input  wire logic i_clk, i_rst_n, i_req,
  output logic      o_ack
);
  logic [7:0] cnt_ff;
  // slow supply: ack stays up until the request falls
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) cnt_ff <= 8'h00;
    else cnt_ff <= i_req ? cnt_ff + 8'h01 : 8'h00;
  assign o_ack = cnt_ff >= 8'(DLY);
endmodule : swg_seq_model
`default_nettype wire

// [tb/swg_wake_props.sv]
// port assertions for swg_wake
`timescale 1ns/1ps
`default_nettype none
module swg_wake_props (
  // clock, reset and inputs
  input wire logic i_clk, i_rst_n, i_pcie_wake, i_pwr_btn, i_pwr_ack,
  // design outputs
  input wire logic o_pwr_up_req, o_resume, o_main_pwr_en, o_drive_pwr_en, o_fan_en, o_led,
  input wire swg_pkg::swg_state_t o_state
);
  import swg_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_fan_s0: assert property (o_fan_en == (o_state == SWG_S0))
    else $error("fan not s0 only");
  a_s3_rails: assert property (o_state == SWG_S3 |-> !(o_drive_pwr_en | o_main_pwr_en))
    else $error("rails on in s3");
  a_s3_blink: assert property (not ((o_state == SWG_S3 && $stable(o_led)) [*6]))
    else $error("led not blinking");
  a_req_held: assert property (o_pwr_up_req && !i_pwr_ack && !i_pwr_btn |=> o_pwr_up_req)
    else $error("wake request lost");
  a_ack_s0: assert property (o_pwr_up_req && i_pwr_ack |=> o_state == SWG_S0)
    else $error("ack did not power up");
  a_pcie_any: assert property ($rose(i_pcie_wake) && !o_fan_en &&
    !o_pwr_up_req |-> ##[1:6] o_pwr_up_req)
    else $error("pcie wake missed");
  a_ctx_resume: assert property (o_pwr_up_req && o_state == SWG_S3 |-> o_resume)
    else $error("s3 wake not resume");
  a_cold_boot: assert property (o_pwr_up_req && o_state == SWG_S5 |-> !o_resume)
    else $error("s5 wake not cold");
endmodule : swg_wake_props
`default_nettype wire

// [tb/swg_wake_test.sv]
// self-checking bench for swg_wake
`timescale 1ns/1ps
`default_nettype none
module swg_wake_test;
  import swg_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, slp = 1'b0, pme_en = 1'b1, s5_en = 1'b0;
  logic       ack, req, res, lan, mpw, dpw, fan, led;
  logic [7:0] pin = 8'h00;
  swg_state_t tgt = SWG_S0, st;
  swg_state_t tg[4] = '{SWG_S1, SWG_S3, SWG_S4, SWG_S5};
  int         n_mismatch = 0, samples_checked = 0;
  swg_wake #(.HOLD_CYCLES(20), .BLINK_CYCLES(4)) swg_wake_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_sleep_req(slp), .i_sleep_tgt(tgt), .i_pme_en(pme_en), .i_kbd_s5_en(s5_en),
    .i_lan_match(pin[0]), .i_usb_act(pin[1]), .i_pme(pin[2]), .i_kbd_act(pin[3]),
    .i_kbd_hotkey(pin[4]), .i_pcie_wake(pin[5]), .i_ser_act(pin[6]), .i_pwr_btn(pin[7]),
    .i_pwr_ack(ack), .o_pwr_up_req(req), .o_resume(res), .o_lan_wake(lan),
    .o_main_pwr_en(mpw), .o_drive_pwr_en(dpw), .o_fan_en(fan), .o_led(led), .o_state(st));
  swg_seq_model #(.DLY(12)) swg_seq_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_req(req),
    .o_ack(ack));
  initial forever #4 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  // pin dropped well before the slow ack, so only a latched request wakes
  task automatic pulse_wait(input int i);
    pin[i] <= 1'b1;
    tick(6);
    chk(8'(lan), 8'(i == 0));
    pin[i] <= 1'b0;
    for (int k = 0; k < 40 && st !== SWG_S0; k++) tick(1);
  endtask : pulse_wait
  task automatic sleep_to(input swg_state_t t);
    tgt <= t;
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(2);
    chk(8'(st), 8'(t));
    if (t == SWG_S3) chk({5'h00, mpw, dpw, fan}, 8'h00);
  endtask : sleep_to
  task automatic try_wake(input swg_state_t t, input int i, input logic exp);
    sleep_to(t);
    pulse_wait(i);
    chk(8'(st === SWG_S0), 8'(exp));
    if (exp) chk({4'h0, mpw, dpw, fan, led}, 8'h0F);
    if (exp) chk(8'(res), 8'(t != SWG_S5));
    if (!exp) pulse_wait(5);
  endtask : try_wake
  // cold start: pcie wake from the reset state
  task automatic t_first_wake;
    pulse_wait(5);
    chk(8'(st), 8'(SWG_S0));
    chk(8'(res), 8'h00);
    $display("first wake test done");
  endtask : t_first_wake
  // sleep entry refused while asleep and for codes outside the sleep set
  task automatic t_refuse;
    sleep_to(SWG_S3);
    tgt <= SWG_S1;
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(2);
    chk(8'(st), 8'(SWG_S3));
    pulse_wait(5);
    chk(8'(st), 8'(SWG_S0));
    tgt <= swg_state_t'(5'h03);
    slp <= 1'b1;
    tick(1);
    slp <= 1'b0;
    tick(2);
    chk(8'(st), 8'(SWG_S0));
    $display("refuse test done");
  endtask : t_refuse
  task automatic t_sources;
    for (int p = 0; p < 2; p++) begin
      pme_en <= (p == 0);
      s5_en <= (p == 1);
      for (int s = 0; s < 4; s++)
        for (int i = 0; i < 7; i++)
          try_wake(tg[s], i, (i == 2) ? (p == 0) : (i == 0 || i == 5 || s < 2 ||
                   (i == 4 && p == 1)));
    end
    $display("sources test done");
  endtask : t_sources
  task automatic press(input int n, input swg_state_t exp);
    pin[7] <= 1'b1;
    tick(n);
    pin[7] <= 1'b0;
    tick(30);
    chk(8'(st), 8'(exp));
  endtask : press
  // long press from s3 must not be read as a short wake
  task automatic t_button;
    press(8, SWG_S5);
    press(8, SWG_S0);
    press(35, SWG_S5);
    press(8, SWG_S0);
    sleep_to(SWG_S3);
    press(35, SWG_S5);
    $display("button test done");
  endtask : t_button
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(2);
    t_first_wake();
    t_sources();
    t_refuse();
    t_button();
    final_report();
  end
  // tests take roughly 2,400 cycles; this allows about five times that
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
endmodule : swg_wake_test
bind swg_wake swg_wake_props swg_wake_props_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_pcie_wake(i_pcie_wake), .i_pwr_btn(i_pwr_btn), .i_pwr_ack(i_pwr_ack),
  .o_pwr_up_req(o_pwr_up_req), .o_resume(o_resume), .o_main_pwr_en(o_main_pwr_en),
  .o_drive_pwr_en(o_drive_pwr_en), .o_fan_en(o_fan_en), .o_led(o_led), .o_state(o_state));
`default_nettype wire
